// ===== core/eep_pkg.sv
// shared constants and types of the two-wire serial memory slave.
// assumes one 100 MHz clock and a synchronous active-high reset.
//
// Summary of operation
// - start is sda falling while scl high
// - sda changes only while scl is low
// - stop is sda rising while scl high
// - receiver acknowledges each byte by pulling low
// - standby after reset, non-write stop, write done
// - answer only device code 1010
// - address bits 3..1 match strap pins
// - address bit 0: one reads, zero writes
// - matching address acknowledged on ninth clock
// - byte write programs only after stop
// - busy programming ignores everything, no acknowledge
// - page write takes up to 32 bytes
// - data acknowledged, low five address bits increment
// - over 32 bytes wrap and overwrite buffer
// - stop starts the write, page copied over its first 32 cycles
// - internal write lasts at most 5 ms
// - write protect high blocks array writes
// - current read returns byte at counter
// - random read: dummy write then read
// - each master ack gives next byte
// - read address wraps from last to zero

`default_nettype none

package eep_pkg;

	// array geometry
	localparam int ADDR_W = 12;
	localparam int MEM_DEPTH = 4096;
	localparam int PAGE_W = 5;
	localparam int PAGE_BYTES = 32;
	localparam int HI_ADDR_W = ADDR_W - 8;

	// slave address byte layout
	localparam logic [3:0] DEV_CODE = 4'hA;
	localparam int SA_CODE_LSB = 4;
	localparam int SA_SEL_LSB = 1;
	localparam int SA_RW_BIT = 0;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// synchroniser lanes
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_SEL_LSB = 2;
	localparam int PIN_WP = 5;
	localparam int PIN_COUNT = 6;

	// internal write time
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int WR_TIME_MS = 5;
	localparam int WR_CYCLES = WR_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DEV,
		ST_DEV_ACK,
		ST_AHI,
		ST_AHI_ACK,
		ST_ALO,
		ST_ALO_ACK,
		ST_WDAT,
		ST_WDAT_ACK,
		ST_RDAT,
		ST_RACK
	} eep_state_t;

endpackage : eep_pkg

`default_nettype wire

// ===== core/eep_mem_if.sv
// byte port between the protocol logic and the storage array.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface eep_mem_if #(
	parameter int AW = 12
);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [7:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [7:0] rd_data;

	modport ctrl (
		output wr_en, wr_addr, wr_data, rd_addr,
		input rd_data
	);
	modport mem (
		input wr_en, wr_addr, wr_data, rd_addr,
		output rd_data
	);
endinterface : eep_mem_if

`default_nettype wire

// ===== core/eep_sync.sv
// two-flop synchronisers for pins, with edge pulses after the second stage.
// assumes pins are asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none

module eep_sync #(
	parameter int WIDTH = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// raw pins
	input wire logic [WIDTH-1:0] raw,
	// synchronised levels and edges
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] dly_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= '1;
			sync_ff <= '1;
			dly_ff <= '1;
		end else begin
			meta_ff <= raw;
			sync_ff <= meta_ff;
			dly_ff <= sync_ff;
		end
	end

	assign level = sync_ff;
	assign rise = sync_ff & ~dly_ff;
	assign fall = ~sync_ff & dly_ff;
endmodule : eep_sync

`default_nettype wire

// ===== core/eep_mem.sv
// byte-wide storage array held in flip-flops, combinational read.
// assumes one write per cycle from the protocol logic.
`timescale 1ns/10ps
`default_nettype none

module eep_mem #(
	parameter int DEPTH = eep_pkg::MEM_DEPTH
) (
	// clock
	input wire logic clk,
	// byte port
	eep_mem_if.mem port
);
	logic [7:0] cell_ff [DEPTH];

	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			cell_ff[port.wr_addr] <= port.wr_data;
		end
	end

	assign port.rd_data = cell_ff[port.rd_addr];
endmodule : eep_mem

`default_nettype wire

// ===== core/eep_slave.sv
// two-wire serial memory slave: protocol, page buffer and timed write.
// assumes scl, sda and straps are asynchronous pins, sda open drain.
`timescale 1ns/10ps
`default_nettype none

module eep_slave #(
	parameter int WR_CYCLES = eep_pkg::WR_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// two-wire bus
	input wire logic scl,
	input wire logic sda,
	output logic sda_value,
	output logic sda_oe,
	// straps and protection
	input wire logic chip_select_strap_0,
	input wire logic chip_select_strap_1,
	input wire logic chip_select_strap_2,
	input wire logic write_protect,
	// status
	output logic standby,
	output logic write_busy
);
	localparam int TW = $clog2(WR_CYCLES + 1);
	localparam logic [TW-1:0] TMR_LAST = TW'(WR_CYCLES - 1);
	localparam logic [TW-1:0] TMR_PAGE = TW'(eep_pkg::PAGE_BYTES);
	localparam int AW = eep_pkg::ADDR_W;
	localparam int PW = eep_pkg::PAGE_W;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [eep_pkg::PIN_COUNT-1:0] pin_s;
	logic [eep_pkg::PIN_COUNT-1:0] pin_rise;
	logic [eep_pkg::PIN_COUNT-1:0] pin_fall;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [2:0] sel_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	eep_sync #(
		.WIDTH(eep_pkg::PIN_COUNT)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.raw({write_protect, chip_select_strap_2, chip_select_strap_1,
			chip_select_strap_0, sda, scl}),
		.level(pin_s),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	assign scl_s = pin_s[eep_pkg::PIN_SCL];
	assign sda_s = pin_s[eep_pkg::PIN_SDA];
	assign wp_s = pin_s[eep_pkg::PIN_WP];
	assign sel_s = pin_s[eep_pkg::PIN_SEL_LSB +: 3];
	assign scl_rise = pin_rise[eep_pkg::PIN_SCL];
	assign scl_fall = pin_fall[eep_pkg::PIN_SCL];
	assign start_det = pin_fall[eep_pkg::PIN_SDA] & scl_s;
	assign stop_det = pin_rise[eep_pkg::PIN_SDA] & scl_s;

	////////////////////////////////////////////////////////////////////////
	// storage array

	eep_mem_if #(.AW(AW)) mem_bus ();

	eep_mem #(
		.DEPTH(eep_pkg::MEM_DEPTH)
	) u_mem (
		.clk(clk),
		.port(mem_bus.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// state

	eep_pkg::eep_state_t state_ff;
	logic [3:0] bitcnt_ff;
	logic [7:0] shift_ff;
	logic rw_ff;
	logic [AW-1:0] addr_ff;
	logic sda_oe_ff;
	logic sda_out_ff;
	logic busy_ff;
	logic standby_ff;
	logic [TW-1:0] tmr_ff;
	logic [7:0] pbuf_ff [eep_pkg::PAGE_BYTES];
	logic [eep_pkg::PAGE_BYTES-1:0] pval_ff;
	logic [AW-PW-1:0] page_ff;

	logic bus_free;
	logic rx_done;
	logic wdat_done;
	logic commit_go;
	logic write_end;
	logic [PW-1:0] commit_idx;

	// slave address byte decode against the straps
	function automatic logic dev_match(input logic [7:0] b,
		input logic [2:0] sel);
		dev_match = (b[eep_pkg::SA_CODE_LSB +: 4] == eep_pkg::DEV_CODE) &&
			(b[eep_pkg::SA_SEL_LSB +: 3] == sel);
	endfunction : dev_match

	// protocol only acts when not programming and no start or stop now
	assign bus_free = !busy_ff && !start_det && !stop_det;
	assign rx_done = bus_free && scl_fall && (bitcnt_ff == eep_pkg::BYTE_BITS);
	assign wdat_done = rx_done && (state_ff == eep_pkg::ST_WDAT);
	assign commit_go = !busy_ff && stop_det && (|pval_ff) && !wp_s;
	assign write_end = busy_ff && (tmr_ff == TMR_LAST);
	assign commit_idx = tmr_ff[PW-1:0];

	////////////////////////////////////////////////////////////////////////
	// bus protocol

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= eep_pkg::ST_IDLE;
			bitcnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			rw_ff <= 1'h0;
			addr_ff <= '0;
			sda_oe_ff <= 1'h0;
		end else if (busy_ff) begin
			state_ff <= eep_pkg::ST_IDLE;
			sda_oe_ff <= 1'h0;
		end else if (start_det) begin
			state_ff <= eep_pkg::ST_DEV;
			bitcnt_ff <= 4'h0;
			sda_oe_ff <= 1'h0;
		end else if (stop_det) begin
			state_ff <= eep_pkg::ST_IDLE;
			sda_oe_ff <= 1'h0;
		end else begin
			case (state_ff)
				eep_pkg::ST_IDLE: begin
					sda_oe_ff <= 1'h0;
				end
				eep_pkg::ST_DEV, eep_pkg::ST_AHI, eep_pkg::ST_ALO,
				eep_pkg::ST_WDAT: begin
					if (scl_rise && bitcnt_ff < eep_pkg::BYTE_BITS) begin
						shift_ff <= {shift_ff[6:0], sda_s};
						bitcnt_ff <= bitcnt_ff + 4'h1;
					end else if (rx_done) begin
						bitcnt_ff <= 4'h0;
						sda_oe_ff <= 1'h1;
						case (state_ff)
							eep_pkg::ST_DEV: begin
								if (dev_match(shift_ff, sel_s)) begin
									rw_ff <= shift_ff[eep_pkg::SA_RW_BIT];
									state_ff <= eep_pkg::ST_DEV_ACK;
								end else begin
									sda_oe_ff <= 1'h0;
									state_ff <= eep_pkg::ST_IDLE;
								end
							end
							eep_pkg::ST_AHI: begin
								// unused upper address bits dropped
								addr_ff[AW-1:8] <=
									shift_ff[eep_pkg::HI_ADDR_W-1:0];
								state_ff <= eep_pkg::ST_AHI_ACK;
							end
							eep_pkg::ST_ALO: begin
								addr_ff[7:0] <= shift_ff;
								state_ff <= eep_pkg::ST_ALO_ACK;
							end
							default: begin
								// page counter wraps, upper bits hold
								addr_ff[PW-1:0] <= addr_ff[PW-1:0] + 5'h01;
								state_ff <= eep_pkg::ST_WDAT_ACK;
							end
						endcase
					end
				end
				eep_pkg::ST_DEV_ACK, eep_pkg::ST_AHI_ACK,
				eep_pkg::ST_ALO_ACK, eep_pkg::ST_WDAT_ACK: begin
					if (scl_fall) begin
						sda_oe_ff <= 1'h0;
						case (state_ff)
							eep_pkg::ST_DEV_ACK: begin
								if (rw_ff) begin
									shift_ff <= mem_bus.rd_data;
									sda_oe_ff <= ~mem_bus.rd_data[7];
									addr_ff <= addr_ff + 12'h001;
									state_ff <= eep_pkg::ST_RDAT;
								end else begin
									state_ff <= eep_pkg::ST_AHI;
								end
							end
							eep_pkg::ST_AHI_ACK: state_ff <= eep_pkg::ST_ALO;
							default: state_ff <= eep_pkg::ST_WDAT;
						endcase
					end
				end
				eep_pkg::ST_RDAT: begin
					if (scl_rise && bitcnt_ff < eep_pkg::BYTE_BITS) begin
						bitcnt_ff <= bitcnt_ff + 4'h1;
					end else if (scl_fall && bitcnt_ff == eep_pkg::BYTE_BITS) begin
						bitcnt_ff <= 4'h0;
						sda_oe_ff <= 1'h0;
						state_ff <= eep_pkg::ST_RACK;
					end else if (scl_fall && bitcnt_ff != 4'h0) begin
						shift_ff <= {shift_ff[6:0], 1'h0};
						sda_oe_ff <= ~shift_ff[6];
					end
				end
				eep_pkg::ST_RACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							state_ff <= eep_pkg::ST_IDLE;
						end else begin
							bitcnt_ff <= 4'h1;
						end
					end else if (scl_fall && bitcnt_ff == 4'h1) begin
						bitcnt_ff <= 4'h0;
						shift_ff <= mem_bus.rd_data;
						sda_oe_ff <= ~mem_bus.rd_data[7];
						addr_ff <= addr_ff + 12'h001;
						state_ff <= eep_pkg::ST_RDAT;
					end
				end
				default: begin
					state_ff <= eep_pkg::ST_IDLE;
					sda_oe_ff <= 1'h0;
				end
			endcase
		end
	end

	// open-drain: the pin only ever drives low
	always_ff @(posedge clk) begin
		sda_out_ff <= 1'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// page buffer

	always_ff @(posedge clk) begin
		if (rst) begin
			pval_ff <= '0;
			page_ff <= '0;
		end else if (write_end) begin
			pval_ff <= '0;
		end else if (!busy_ff && (stop_det || start_det) && !commit_go) begin
			// dummy write, protected write or restart drops the buffer
			pval_ff <= '0;
		end else if (wdat_done) begin
			pval_ff[addr_ff[PW-1:0]] <= 1'h1;
			page_ff <= addr_ff[AW-1:PW];
		end
	end

	always_ff @(posedge clk) begin
		if (wdat_done) begin
			pbuf_ff[addr_ff[PW-1:0]] <= shift_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timed internal write and standby

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_ff <= 1'h0;
			tmr_ff <= '0;
			standby_ff <= 1'h1;
		end else if (busy_ff) begin
			if (write_end) begin
				busy_ff <= 1'h0;
				tmr_ff <= '0;
				standby_ff <= 1'h1;
			end else begin
				tmr_ff <= tmr_ff + 1'h1;
			end
		end else if (stop_det) begin
			busy_ff <= commit_go;
			standby_ff <= !commit_go;
		end else if (start_det) begin
			standby_ff <= 1'h0;
		end
	end

	// the page is copied during the first cycles of the write time
	assign mem_bus.wr_en = busy_ff && (tmr_ff < TMR_PAGE) &&
		pval_ff[commit_idx];
	assign mem_bus.wr_addr = {page_ff, commit_idx};
	assign mem_bus.wr_data = pbuf_ff[commit_idx];
	assign mem_bus.rd_addr = addr_ff;

	assign sda_value = sda_out_ff;
	assign sda_oe = sda_oe_ff;
	assign standby = standby_ff;
	assign write_busy = busy_ff;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_dev_byte_in;
		bus_free && state_ff == eep_pkg::ST_DEV && rx_done;
	endsequence

	sequence s_stop_commit;
		!busy_ff && stop_det && (|pval_ff) && !wp_s;
	endsequence

	a_start_resync: assert property (
		!busy_ff && start_det |=> state_ff == eep_pkg::ST_DEV &&
			bitcnt_ff == 4'h0 && !sda_oe_ff)
		else $error("start did not restart address phase");

	a_stop_release: assert property (
		!busy_ff && stop_det |=> !sda_oe_ff &&
			state_ff == eep_pkg::ST_IDLE)
		else $error("stop did not release the bus");

	a_busy_silent: assert property (
		busy_ff |=> !sda_oe_ff && state_ff == eep_pkg::ST_IDLE)
		else $error("device answered while programming");

	a_addr_ack: assert property (
		s_dev_byte_in ##0 dev_match(shift_ff, sel_s) |=>
			sda_oe_ff && state_ff == eep_pkg::ST_DEV_ACK)
		else $error("matching address not acknowledged");

	a_addr_ignore: assert property (
		s_dev_byte_in ##0 !dev_match(shift_ff, sel_s) |=>
			!sda_oe_ff && state_ff == eep_pkg::ST_IDLE)
		else $error("foreign address acknowledged");

	a_stop_commit: assert property (
		s_stop_commit |=> busy_ff && !standby_ff && tmr_ff == '0)
		else $error("stop with data did not start write");

	a_protect_block: assert property (
		!busy_ff && stop_det && wp_s |=> !busy_ff && standby_ff)
		else $error("write started while protected");

	a_write_bound: assert property (
		busy_ff |-> tmr_ff <= TMR_LAST)
		else $error("write cycle overran its time");

	a_write_finish: assert property (
		write_end |=> !busy_ff && standby_ff && pval_ff == '0)
		else $error("write end did not return to standby");

	a_page_wrap: assert property (
		wdat_done |=> addr_ff[AW-1:PW] == $past(addr_ff[AW-1:PW]) &&
			addr_ff[PW-1:0] == $past(addr_ff[PW-1:0]) + 5'h01)
		else $error("page address did not wrap in page");

	a_read_step: assert property (
		bus_free && state_ff == eep_pkg::ST_RACK && scl_fall &&
			bitcnt_ff == 4'h1 |=> state_ff == eep_pkg::ST_RDAT &&
			addr_ff == $past(addr_ff) + 12'h001)
		else $error("sequential read did not advance");
endmodule : eep_slave

`default_nettype wire

// ===== sim/eep_bus_master.sv
// two-wire bus master model: start, stop, bit and byte cycles.
// assumes the bench resolves sda from all pull-downs and a pull-up.
`timescale 1ns/10ps
`default_nettype none

module eep_bus_master (
	// clock
	input wire logic clk,
	// bus
	input wire logic sda,
	output var logic scl,
	output var logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one bit: 4 clk low then 4 clk high, 80 ns
	task automatic bit_cyc(input logic b, output logic s);
		@(posedge clk) sda_low <= ~b;
		repeat (3) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		s = sda;
		scl <= 1'b0;
	endtask : bit_cyc

	task automatic start_cond();
		@(posedge clk) sda_low <= 1'b0;
		repeat (3) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_low <= 1'b1;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
	endtask : start_cond

	// scl stays high afterwards, bus idle
	task automatic stop_cond();
		@(posedge clk) sda_low <= 1'b1;
		repeat (3) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_low <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : stop_cond

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
		bit_cyc(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(output logic [7:0] b, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cyc(1'b1, b[i]);
		bit_cyc(~ack, s);
	endtask : recv_byte

	task automatic recover();
		logic s;
		repeat (9) bit_cyc(1'b1, s);
		start_cond();
	endtask : recover
endmodule : eep_bus_master

`default_nettype wire

// ===== sim/serial_eeprom_two_wire_slave_test.sv
// self-checking bench of the two-wire serial memory slave.
// assumes the master model eep_bus_master and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end

module serial_eeprom_two_wire_slave_test;
	localparam int WR = 400;
	logic clk, rst, wp, sda_out, sda_oe, standby, write_busy;
	logic scl, m_low, sda, ack, s;
	logic [2:0] strap;
	logic [7:0] d;
	logic [11:0] a;
	logic [7:0] exp_mem [4096];
	int n_fail, checks, busy_cnt;

	// open drain wire with pull-up
	assign sda = (sda_oe ? sda_out : 1'b1) & ~m_low;

	eep_slave #(.WR_CYCLES(WR)) i_eep_slave (.clk(clk), .rst(rst),
		.scl(scl), .sda(sda), .sda_value(sda_out), .sda_oe(sda_oe),
		.chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
		.chip_select_strap_2(strap[2]), .write_protect(wp),
		.standby(standby), .write_busy(write_busy));
	eep_bus_master i_eep_bus_master (.clk(clk), .sda(sda), .scl(scl),
		.sda_low(m_low));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) if (write_busy === 1'b1) busy_cnt++;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] dev(input logic [2:0] sel, input logic rw);
		return {4'hA, sel, rw};
	endfunction : dev

	function automatic logic [11:0] in_page(input logic [11:0] b, input int k);
		return {b[11:5], 5'(b[4:0] + k)};
	endfunction : in_page

	task automatic tx(input logic [7:0] b, input logic e, input string nm);
		i_eep_bus_master.send_byte(b, ack);
		`CHK(nm, e, ack)
	endtask : tx

	task automatic set_addr(input logic [11:0] b);
		i_eep_bus_master.start_cond();
		tx(dev(strap, 1'b0), 1'b1, "dev w");
		tx({4'h0, b[11:8]}, 1'b1, "addr hi");
		tx(b[7:0], 1'b1, "addr lo");
	endtask : set_addr

	task automatic wr(input logic [11:0] b, input int n);
		set_addr(b);
		for (int k = 0; k < n; k++) begin
			d = 8'($urandom);
			tx(d, 1'b1, "data ack");
			if (!wp) exp_mem[in_page(b, k)] = d;
		end
		busy_cnt = 0;
		i_eep_bus_master.stop_cond();
	endtask : wr

	task automatic wait_done();
		int nacks = 0;
		ack = 1'b0;
		for (int p = 0; p < 20 && !ack; p++) begin
			i_eep_bus_master.start_cond();
			i_eep_bus_master.send_byte(dev(strap, 1'b0), ack);
			i_eep_bus_master.stop_cond();
			if (!ack) nacks++;
		end
		`CHK("busy nacks", 1'b1, nacks > 0)
		`CHK("ready ack", 1'b1, ack)
		`CHK("busy clocks", WR, busy_cnt)
		`CHK("standby", 1'b1, standby)
	endtask : wait_done

	task automatic rd(input logic [11:0] b, input int n, input logic rnd);
		if (rnd) set_addr(b);
		i_eep_bus_master.start_cond();
		tx(dev(strap, 1'b1), 1'b1, "dev r");
		for (int k = 0; k < n; k++) begin
			i_eep_bus_master.recv_byte(d, k < n - 1);
			`CHK("read", exp_mem[12'(b + k)], d)
		end
		i_eep_bus_master.stop_cond();
		`CHK("read standby", 1'b1, standby)
	endtask : rd

	task automatic end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////
	initial begin
		#300000;
		n_fail++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'hD749D2B0));
		rst = 1'b1;
		wp = 1'b0;
		strap = 3'h0;
		n_fail = 0;
		checks = 0;
		busy_cnt = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		strap <= 3'($urandom);
		repeat (4) @(posedge clk);
		`CHK("rst standby", 1'b1, standby)
		`CHK("rst busy", 1'b0, write_busy)
		`CHK("rst oe", 1'b0, sda_oe)
		`CHK("rst drive", 1'b0, sda_out)
		$display("test reset done");
		for (int k = 0; k < 9; k++) begin
			i_eep_bus_master.start_cond();
			if (k < 8)
				tx({4'hA, 3'(k), 1'b0}, 3'(k) == strap, "select");
			else
				tx({4'($urandom % 10), strap, 1'b0}, 1'b0, "code");
			i_eep_bus_master.stop_cond();
		end
		`CHK("no write", 1'b0, write_busy)
		$display("test address done");
		wr(12'hFFF, 1);
		wait_done();
		$display("test byte write done");
		wr(12'h01E, 34);
		wait_done();
		$display("test page write done");
		rd(12'hFFF, 33, 1'b1);
		$display("test sequential read done");
		a = 12'($urandom % 30);
		rd(a, 1, 1'b1);
		rd(a + 12'h001, 1, 1'b0);
		$display("test current read done");
		wp <= 1'b1;
		wr(12'h004, 4);
		repeat (20) @(posedge clk);
		`CHK("wp busy", 1'b0, write_busy)
		wp <= 1'b0;
		rd(12'h004, 4, 1'b1);
		$display("test protect done");
		i_eep_bus_master.start_cond();
		tx(dev(strap, 1'b1), 1'b1, "dev r");
		repeat (3) i_eep_bus_master.bit_cyc(1'b1, s);
		i_eep_bus_master.recover();
		tx(dev(strap, 1'b0), 1'b1, "recovered");
		i_eep_bus_master.stop_cond();
		$display("test recovery done");
		end_of_test();
	end
endmodule : serial_eeprom_two_wire_slave_test

`default_nettype wire
